// ===== dv/pin_timer_irq_sources_tb_top.sv
`timescale 1ns/100ps
`include "ptis_consts.vh"
// ********************
// Bench for the interrupt source block
// ********************
module pin_timer_irq_sources_tb_top;
    reg clock_i = 1'h0;
    reg rstn_i = 1'h0;
    reg [3:0] address_i = 4'h0;
    reg read_i = 1'h0;
    reg write_i = 1'h0;
    reg [31:0] writedata_i = 32'h0;
    wire [31:0] readdata_o;
    wire waitrequest_o, irq_o, pending_o, vector_high_o, vector_low_o, wake_vector_o, wake_resume_o, stack_full_o;
    wire [2:0] ext_pins_i;
    wire [3:0] port_pins_i, core_bank_i, shadow_bank_o;
    wire core_sleep_i, core_take_i, core_return_i;
    wire [20:0] core_pc_i, return_pc_o;
    wire [7:0] core_working_i, core_status_i, shadow_working_o, shadow_status_o;
    integer seed = 32'hda27a90f;
    integer fails = 0;
    integer n_checks = 0;
    integer cyc = 0;
    integer n, k, i;
    reg [7:0] q, m;
    reg [20:0] pc;
    reg [19:0] ctx;
    reg pol, lvl, p, e;
    ptis_irq_top u_dut (.clock_i, .rstn_i, .address_i, .read_i, .write_i, .writedata_i, .readdata_o, .waitrequest_o,
        .irq_o, .ext_pins_i, .port_pins_i, .core_sleep_i, .core_take_i, .core_return_i, .core_pc_i, .core_working_i,
        .core_status_i, .core_bank_i, .pending_o, .vector_high_o, .vector_low_o, .wake_vector_o, .wake_resume_o,
        .return_pc_o, .shadow_working_o, .shadow_status_o, .shadow_bank_o, .stack_full_o);
    ptis_partner u_far (.clock_i, .ext_pins_o(ext_pins_i), .port_pins_o(port_pins_i), .core_sleep_o(core_sleep_i),
        .core_take_o(core_take_i), .core_return_o(core_return_i), .core_pc_o(core_pc_i),
        .core_working_o(core_working_i), .core_status_o(core_status_i), .core_bank_o(core_bank_i));
    // Free-running 10 MHz clock.
    always #50 clock_i = ~clock_i;
    // Cut a hang short; the run needs under a thousand cycles.
    always @(posedge clock_i) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            fails = fails + 1;
            end_sim;
        end
    end
    // An edge counts only when it moves the pin to the selected level.
    function hit(input pol_f, input from_f);
        hit = (!from_f == pol_f);
    endfunction
    // Register holding one external pin's flag.
    function [3:0] flag_reg(input integer s);
        flag_reg = (s == 0) ? `PTIS_REG_MAIN : `PTIS_REG_THIRD;
    endfunction
    task chk(input [95:0] nm, input [20:0] seen, input [20:0] exp);
        begin
            n_checks = n_checks + 1;
            if (seen !== exp) begin
                fails = fails + 1;
                $display("mismatch %0s exp %h seen %h", nm, exp, seen);
            end
        end
    endtask
    // One bus access, held until the edge that sees the wait released.
    task bus(input w, input [3:0] a, input [7:0] d);
        begin
            address_i <= a;
            write_i <= w;
            read_i <= !w;
            writedata_i <= {24'h0, d};
            @(posedge clock_i);
            while (waitrequest_o !== 1'h0) @(posedge clock_i);
            q = readdata_o[7:0];
            read_i <= 1'h0;
            write_i <= 1'h0;
            @(posedge clock_i);
        end
    endtask
    task prio(input [7:0] sec, input [7:0] mn, input hi);
        begin
            bus(1, `PTIS_REG_SECOND, sec);
            bus(1, `PTIS_REG_MAIN, mn);
            chk("vec high", vector_high_o, hi);
            chk("vec low", vector_low_o, !hi);
        end
    endtask
    task end_sim;
        begin
            $display("checks %0d fails %0d", n_checks, fails);
            if (fails == 0 && n_checks > 0) begin
                $display("STATUS OK");
            end else begin
                $display("STATUS NOT OK");
            end
            $finish;
        end
    endtask
    // ********************
    // Main sequence
    // ********************
    initial begin
        repeat (20) @(posedge clock_i);
        rstn_i <= 1'h1;
        repeat (3) @(posedge clock_i);
        bus(0, `PTIS_REG_SECOND, 8'h0);
        chk("second", q, 8'h75);
        bus(1, 4'h9, 8'h5a);
        bus(0, 4'h9, 8'h0);
        chk("unmapped", q, 8'h0);
        $display("test reset done");
        // Each pin in turn, with random polarity, priority and mask per pass; a wrong-way edge must be ignored.
        for (n = 0; n < 12; n = n + 1) begin
            i = n % 3;
            pol = $random(seed);
            lvl = $random(seed);
            p = $random(seed);
            m = $random(seed);
            e = hit(pol, lvl);
            bus(1, `PTIS_REG_SECOND, {1'h0, pol, pol, pol, 4'h5});
            u_far.set_pins((ext_pins_i & ~(3'h1 << i)) | ({2'h0, lvl} << i), port_pins_i);
            bus(1, `PTIS_REG_MAIN, 8'h0);
            bus(1, `PTIS_REG_THIRD, 8'h0);
            bus(1, `PTIS_REG_STATUS, 8'hff);
            bus(1, `PTIS_REG_MASK, m);
            u_far.set_pins(ext_pins_i ^ (3'h1 << i), port_pins_i);
            bus(0, flag_reg(i), 8'h0);
            chk("ext flag", q[i != 1], e);
            bus(0, `PTIS_REG_STATUS, 8'h0);
            chk("ext event", q[i], e);
            chk("pending off", pending_o, 1'h0);
            chk("irq", irq_o, e & m[i]);
            bus(1, `PTIS_REG_THIRD, {p & (i == 2), p & (i == 1), 1'h0, i == 2, i == 1, 1'h0, e & (i == 2), e & (i == 1)});
            bus(1, `PTIS_REG_MAIN, {1'h1, 2'h0, i == 0, 2'h0, e & (i == 0), 1'h0});
            chk("pending", pending_o, e);
            chk("vec high", vector_high_o, e & (i == 0 | p));
            chk("vec low", vector_low_o, e & i != 0 & !p);
            if (e) begin
                pc = $random(seed);
                ctx = $random(seed);
                u_far.take(pc, ctx);
                chk("ret pc", return_pc_o, pc);
                chk("shadow", {shadow_working_o, shadow_status_o, shadow_bank_o}, ctx);
                chk("vec taken", vector_high_o | vector_low_o, 1'h0);
                bus(0, flag_reg(i), 8'h0);
                chk("flag held", q[i != 1], 1'h1);
                u_far.ret;
            end
        end
        repeat (31) u_far.take(pc, ctx);
        chk("stack full", stack_full_o, 1'h1);
        bus(1, `PTIS_REG_THIRD, 8'h0);
        $display("test ext done");
        // Wrap in eight-bit mode, low wrap only and full wrap in sixteen-bit mode.
        for (k = 0; k < 3; k = k + 1) begin
            bus(1, `PTIS_REG_TMODE, 8'h0);
            bus(1, `PTIS_REG_MAIN, 8'h0);
            bus(1, `PTIS_REG_THIGH, (k == 2) ? 8'hff : 8'h0);
            bus(1, `PTIS_REG_TLOW, 8'hfe);
            bus(1, `PTIS_REG_TMODE, {6'h0, 1'h1, k != 0});
            repeat (4) @(posedge clock_i);
            bus(1, `PTIS_REG_TMODE, 8'h0);
            bus(0, `PTIS_REG_MAIN, 8'h0);
            chk("timer flag", q[2], k != 1);
        end
        p = $random(seed);
        prio({5'he, p, 2'h1}, 8'ha4, p);
        $display("test timer done");
        // One change on each port pin in turn.
        for (k = 0; k < 4; k = k + 1) begin
            bus(1, `PTIS_REG_MAIN, 8'h0);
            bus(1, `PTIS_REG_STATUS, 8'hff);
            u_far.set_pins(ext_pins_i, port_pins_i ^ (4'h1 << k));
            bus(0, `PTIS_REG_MAIN, 8'h0);
            chk("port flag", q[0], 1'h1);
            bus(0, `PTIS_REG_STATUS, 8'h0);
            chk("port event", q[4], 1'h1);
            p = $random(seed);
            prio({6'h1d, 1'h0, p}, 8'h89, p);
        end
        $display("test port done");
        // Wake with and without the global enable.
        for (k = 0; k < 2; k = k + 1) begin
            u_far.set_pins(3'h0, port_pins_i);
            bus(1, `PTIS_REG_SECOND, 8'h75);
            bus(1, `PTIS_REG_THIRD, 8'h0);
            bus(1, `PTIS_REG_MAIN, {k[0], 7'h10});
            u_far.set_sleep(1'h1);
            u_far.set_pins(3'h1, port_pins_i);
            for (n = 0; n < 12 && wake_vector_o !== 1'h1 && wake_resume_o !== 1'h1; n = n + 1) @(posedge clock_i);
            chk("wake vec", wake_vector_o, k[0]);
            chk("wake res", wake_resume_o, !k[0]);
            u_far.set_sleep(1'h0);
        end
        $display("test wake done");
        end_sim;
    end
endmodule // pin_timer_irq_sources_tb_top

// ===== dv/ptis_irq_top_monitor.sv
`timescale 1ns/100ps
`include "ptis_consts.vh"
// ********************
// Port checker for the interrupt source block
// ********************
module ptis_irq_top_monitor (
    input wire clock_i,
    input wire rstn_i,
    input wire read_i,
    input wire write_i,
    input wire waitrequest_o,
    input wire core_sleep_i,
    input wire core_take_i,
    input wire [`PTIS_PCW-1:0] core_pc_i,
    input wire [7:0] core_working_i,
    input wire [7:0] core_status_i,
    input wire [3:0] core_bank_i,
    input wire pending_o,
    input wire vector_high_o,
    input wire vector_low_o,
    input wire wake_vector_o,
    input wire wake_resume_o,
    input wire [`PTIS_PCW-1:0] return_pc_o,
    input wire [7:0] shadow_working_o,
    input wire [7:0] shadow_status_o,
    input wire [3:0] shadow_bank_o
);
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!rstn_i);
    // The bus answers after exactly one wait cycle and never stalls an idle bus.
    property p_wait_idle; !read_i && !write_i |-> !waitrequest_o; endproperty
    a_wait_idle: assert property (p_wait_idle) else $error("wait raised without a request");
    property p_wait_one; (read_i || write_i) && waitrequest_o |=> !waitrequest_o; endproperty
    a_wait_one: assert property (p_wait_one) else $error("bus answer not after one wait cycle");
    // Taking an interrupt stores the return address and context and masks vectoring.
    property p_take_pc; core_take_i |=> return_pc_o == $past(core_pc_i); endproperty
    a_take_pc: assert property (p_take_pc) else $error("return address not captured");
    property p_take_ctx; core_take_i |=> {shadow_working_o, shadow_status_o, shadow_bank_o} ==
        $past({core_working_i, core_status_i, core_bank_i}); endproperty
    a_take_ctx: assert property (p_take_ctx) else $error("shadow context not captured");
    property p_take_gie; core_take_i |=> !vector_high_o && !vector_low_o; endproperty
    a_take_gie: assert property (p_take_gie) else $error("vectoring after take");
    // A vector needs a request, and the low vector yields to the high one.
    property p_vec_pending; vector_high_o || vector_low_o |-> pending_o; endproperty
    a_vec_pending: assert property (p_vec_pending) else $error("vector without request");
    property p_vec_excl; !(vector_high_o && vector_low_o); endproperty
    a_vec_excl: assert property (p_vec_excl) else $error("both vectors high");
    // Wake outputs only follow a sleeping core and never both at once.
    property p_wake_sleep; !core_sleep_i && !$past(core_sleep_i) && !$past(core_sleep_i, 2) |->
        !wake_vector_o && !wake_resume_o; endproperty
    a_wake_sleep: assert property (p_wake_sleep) else $error("wake while awake");
    property p_wake_excl; !(wake_vector_o && wake_resume_o); endproperty
    a_wake_excl: assert property (p_wake_excl) else $error("wake both ways");
    c_take: cover property (core_take_i ##1 return_pc_o == $past(core_pc_i));
    c_wake_vec: cover property (wake_vector_o);
    c_vec_low: cover property (vector_low_o);
endmodule // ptis_irq_top_monitor

bind ptis_irq_top ptis_irq_top_monitor u_mon (.clock_i, .rstn_i, .read_i, .write_i, .waitrequest_o, .core_sleep_i,
    .core_take_i, .core_pc_i, .core_working_i, .core_status_i, .core_bank_i, .pending_o, .vector_high_o,
    .vector_low_o, .wake_vector_o, .wake_resume_o, .return_pc_o, .shadow_working_o, .shadow_status_o, .shadow_bank_o);

// ===== dv/ptis_partner.sv
`timescale 1ns/100ps
// ********************
// Pin and core model
// ********************
module ptis_partner (
    input wire clock_i,
    output reg [2:0] ext_pins_o,
    output reg [3:0] port_pins_o,
    output reg core_sleep_o,
    output reg core_take_o,
    output reg core_return_o,
    output reg [20:0] core_pc_o,
    output reg [7:0] core_working_o,
    output reg [7:0] core_status_o,
    output reg [3:0] core_bank_o
);
    reg [19:0] saved;
    // Quiet pins and an idle core from time zero.
    initial begin
        ext_pins_o = 3'h0;
        port_pins_o = 4'h0;
        core_sleep_o = 1'h0;
        core_take_o = 1'h0;
        core_return_o = 1'h0;
        core_pc_o = 21'h0;
        {core_working_o, core_status_o, core_bank_o} = 20'h0;
        saved = 20'h0;
    end
    // Levels are held four edges, longer than the two the synchroniser needs.
    task set_pins(input [2:0] e, input [3:0] p);
        begin
            ext_pins_o <= e;
            port_pins_o <= p;
            repeat (4) @(posedge clock_i);
        end
    endtask
    // Sleep level; its rising edge is where the device arms its wake sources.
    task set_sleep(input s);
        begin
            core_sleep_o <= s;
            @(posedge clock_i);
        end
    endtask
    // The core moves on after the take, so its buses change at once.
    task take(input [20:0] pc, input [19:0] ctx);
        begin
            core_take_o <= 1'h1;
            core_pc_o <= pc;
            {core_working_o, core_status_o, core_bank_o} <= ctx;
            saved <= ctx;
            @(posedge clock_i);
            core_take_o <= 1'h0;
            core_pc_o <= ~pc;
            {core_working_o, core_status_o, core_bank_o} <= ~ctx;
            @(posedge clock_i);
        end
    endtask
    // The handler restores its own saved copy before returning.
    task ret;
        begin
            core_return_o <= 1'h1;
            {core_working_o, core_status_o, core_bank_o} <= saved;
            @(posedge clock_i);
            core_return_o <= 1'h0;
            @(posedge clock_i);
        end
    endtask
endmodule // ptis_partner

// ===== hdl/ptis_consts.vh
`ifndef PTIS_CONSTS_VH
`define PTIS_CONSTS_VH

// ****************************************
// Register word indices on the bus
// ****************************************
`define PTIS_AW 4
`define PTIS_REG_MAIN 4'h0
`define PTIS_REG_SECOND 4'h1
`define PTIS_REG_THIRD 4'h2
`define PTIS_REG_TMODE 4'h3
`define PTIS_REG_TLOW 4'h4
`define PTIS_REG_THIGH 4'h5
`define PTIS_REG_STATUS 4'h6
`define PTIS_REG_MASK 4'h7

// ****************************************
// Main control fields
// ****************************************
`define PTIS_M_GIE 7
`define PTIS_M_TOE 5
`define PTIS_M_E0E 4
`define PTIS_M_PCE 3
`define PTIS_M_TOF 2
`define PTIS_M_E0F 1
`define PTIS_M_PCF 0

// ****************************************
// Second and third control fields
// ****************************************
`define PTIS_S_POL0 6
`define PTIS_S_POL1 5
`define PTIS_S_POL2 4
`define PTIS_S_TOP 2
`define PTIS_S_PCP 0
`define PTIS_T_E2P 7
`define PTIS_T_E1P 6
`define PTIS_T_E2E 4
`define PTIS_T_E1E 3
`define PTIS_T_E2F 1
`define PTIS_T_E1F 0

// ****************************************
// Timer mode fields and widths
// ****************************************
`define PTIS_TM_WIDE 0
`define PTIS_TM_RUN 1
`define PTIS_LOW_MAX 8'hff
`define PTIS_WIDE_MAX 16'hffff

// ****************************************
// Reset values and sizes
// ****************************************
`define PTIS_SECOND_RST 8'h75
`define PTIS_ZERO8 8'h00
`define PTIS_NSRC 6
`define PTIS_STK_DEPTH 31
`define PTIS_STK_FULL 5'h1f
`define PTIS_PCW 21

`endif

// ===== hdl/ptis_irq_top.v
`timescale 1ns/100ps
`include "ptis_consts.vh"
module ptis_irq_top (
    input wire clock_i,
    input wire rstn_i,
    input wire [`PTIS_AW-1:0] address_i,
    input wire read_i,
    input wire write_i,
    input wire [31:0] writedata_i,
    output reg [31:0] readdata_o,
    output wire waitrequest_o,
    output wire irq_o,
    input wire [2:0] ext_pins_i,
    input wire [3:0] port_pins_i,
    input wire core_sleep_i,
    input wire core_take_i,
    input wire core_return_i,
    input wire [`PTIS_PCW-1:0] core_pc_i,
    input wire [7:0] core_working_i,
    input wire [7:0] core_status_i,
    input wire [3:0] core_bank_i,
    output wire pending_o,
    output wire vector_high_o,
    output wire vector_low_o,
    output reg wake_vector_o,
    output reg wake_resume_o,
    output reg [`PTIS_PCW-1:0] return_pc_o,
    output reg [7:0] shadow_working_o,
    output reg [7:0] shadow_status_o,
    output reg [3:0] shadow_bank_o,
    output wire stack_full_o
);
    // ****************************************
    // Reset release
    // ****************************************
    reg rst_meta;
    reg rst_n;

    // Asynchronous assert, synchronous release through two stages.
    always @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
            rst_meta <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_n <= rst_meta;
        end
    end

    // ****************************************
    // Register state
    // ****************************************
    reg [7:0] main_irq_control;
    reg [7:0] second_irq_control;
    reg [7:0] third_irq_control;
    reg [1:0] timer_mode;
    reg [7:0] timer_zero_count_low;
    reg [7:0] timer_zero_count_high;
    reg [`PTIS_NSRC-1:0] event_status;
    reg [`PTIS_NSRC-1:0] event_mask;
    reg ack;
    reg sleep_q;
    reg [2:0] wake_armed;
    reg [4:0] stack_ptr;
    reg [`PTIS_PCW-1:0] stack_mem [0:`PTIS_STK_DEPTH-1];

    wire [2:0] ext_edge;
    wire port_change;
    wire bus_req = read_i | write_i;
    wire wr_done = write_i & ack;

    // Bus write strobe for one register index.
    function wr_hit;
        input [`PTIS_AW-1:0] idx;
        begin
            wr_hit = wr_done & (address_i == idx);
        end
    endfunction

    // Next flag value: hardware set wins over a software write.
    function flag_next;
        input old;
        input set;
        input hit;
        input wbit;
        begin
            flag_next = set | (hit ? wbit : old);
        end
    endfunction

    ptis_pin_events u_pins (
        .clock_i(clock_i),
        .rst_n_i(rst_n),
        .ext_pins_i(ext_pins_i),
        .port_pins_i(port_pins_i),
        .polarity_i({second_irq_control[`PTIS_S_POL2],
                      second_irq_control[`PTIS_S_POL1],
                      second_irq_control[`PTIS_S_POL0]}),
        .ext_edge_o(ext_edge),
        .port_change_o(port_change)
    );

    // ****************************************
    // Timer
    // ****************************************
    wire low_wrap = timer_mode[`PTIS_TM_RUN] & (timer_zero_count_low == `PTIS_LOW_MAX);
    wire wide_wrap = low_wrap & (timer_zero_count_high == `PTIS_LOW_MAX);
    // Eight-bit mode watches only the low byte; wide mode needs the whole pair.
    wire timer_ovf = timer_mode[`PTIS_TM_WIDE] ? wide_wrap : low_wrap;

    // Count while running; a software write of a byte overrides the count.
    always @(posedge clock_i or negedge rst_n) begin
        if (!rst_n) begin
            timer_mode <= 2'b00;
            timer_zero_count_low <= `PTIS_ZERO8;
            timer_zero_count_high <= `PTIS_ZERO8;
        end else begin
            if (wr_hit(`PTIS_REG_TMODE))
                timer_mode <= writedata_i[1:0];
            if (wr_hit(`PTIS_REG_TLOW))
                timer_zero_count_low <= writedata_i[7:0];
            else if (timer_mode[`PTIS_TM_RUN])
                timer_zero_count_low <= timer_zero_count_low + 8'h01;
            if (wr_hit(`PTIS_REG_THIGH))
                timer_zero_count_high <= writedata_i[7:0];
            else if (timer_mode[`PTIS_TM_WIDE] & low_wrap)
                timer_zero_count_high <= timer_zero_count_high + 8'h01;
        end
    end

    // ****************************************
    // Flags, enables and priorities
    // ****************************************
    wire hit_main = wr_hit(`PTIS_REG_MAIN);
    wire hit_third = wr_hit(`PTIS_REG_THIRD);
    wire [7:0] wd = writedata_i[7:0];

    // Flags are sticky: only a bus write or a return to zero by software clears them.
    always @(posedge clock_i or negedge rst_n) begin
        if (!rst_n) begin
            main_irq_control <= `PTIS_ZERO8;
            second_irq_control <= `PTIS_SECOND_RST;
            third_irq_control <= `PTIS_ZERO8;
        end else begin
            main_irq_control[7:3] <= hit_main ? wd[7:3] : main_irq_control[7:3];
            main_irq_control[`PTIS_M_TOF] <= flag_next(main_irq_control[`PTIS_M_TOF],
                timer_ovf, hit_main, wd[`PTIS_M_TOF]);
            main_irq_control[`PTIS_M_E0F] <= flag_next(main_irq_control[`PTIS_M_E0F],
                ext_edge[0], hit_main, wd[`PTIS_M_E0F]);
            main_irq_control[`PTIS_M_PCF] <= flag_next(main_irq_control[`PTIS_M_PCF],
                port_change, hit_main, wd[`PTIS_M_PCF]);
            // Taking an interrupt drops the global enable; return restores it.
            if (core_take_i)
                main_irq_control[`PTIS_M_GIE] <= 1'b0;
            else if (core_return_i)
                main_irq_control[`PTIS_M_GIE] <= 1'b1;
            if (wr_hit(`PTIS_REG_SECOND))
                second_irq_control <= wd;
            third_irq_control[7:2] <= hit_third ? wd[7:2] : third_irq_control[7:2];
            third_irq_control[`PTIS_T_E2F] <= flag_next(third_irq_control[`PTIS_T_E2F],
                ext_edge[2], hit_third, wd[`PTIS_T_E2F]);
            third_irq_control[`PTIS_T_E1F] <= flag_next(third_irq_control[`PTIS_T_E1F],
                ext_edge[1], hit_third, wd[`PTIS_T_E1F]);
        end
    end

    // ****************************************
    // Requests toward the core
    // ****************************************
    // Each source is live only while its flag and its enable are both set.
    wire e0_act = main_irq_control[`PTIS_M_E0F] & main_irq_control[`PTIS_M_E0E];
    wire e1_act = third_irq_control[`PTIS_T_E1F] & third_irq_control[`PTIS_T_E1E];
    wire e2_act = third_irq_control[`PTIS_T_E2F] & third_irq_control[`PTIS_T_E2E];
    wire to_act = main_irq_control[`PTIS_M_TOF] & main_irq_control[`PTIS_M_TOE];
    wire pc_act = main_irq_control[`PTIS_M_PCF] & main_irq_control[`PTIS_M_PCE];
    wire global_irq_enable = main_irq_control[`PTIS_M_GIE];

    // External zero is always high; the others follow their priority bits.
    wire high_req = e0_act |
                    (e1_act & third_irq_control[`PTIS_T_E1P]) |
                    (e2_act & third_irq_control[`PTIS_T_E2P]) |
                    (to_act & second_irq_control[`PTIS_S_TOP]) |
                    (pc_act & second_irq_control[`PTIS_S_PCP]);
    wire low_req = (e1_act & ~third_irq_control[`PTIS_T_E1P]) |
                   (e2_act & ~third_irq_control[`PTIS_T_E2P]) |
                   (to_act & ~second_irq_control[`PTIS_S_TOP]) |
                   (pc_act & ~second_irq_control[`PTIS_S_PCP]);

    assign pending_o = high_req | low_req;
    // Vectoring additionally needs the global enable.
    assign vector_high_o = global_irq_enable & high_req;
    assign vector_low_o = global_irq_enable & low_req & ~high_req;

    // ****************************************
    // Wake from idle or sleep
    // ****************************************
    // Enables are sampled at sleep entry, so enabling later does not wake.
    wire [2:0] ext_en = {third_irq_control[`PTIS_T_E2E], third_irq_control[`PTIS_T_E1E],
                         main_irq_control[`PTIS_M_E0E]};
    wire [2:0] ext_flag = {third_irq_control[`PTIS_T_E2F], third_irq_control[`PTIS_T_E1F],
                           main_irq_control[`PTIS_M_E0F]};
    wire wake = sleep_q & core_sleep_i & |(wake_armed & ext_en & ext_flag);

    always @(posedge clock_i or negedge rst_n) begin
        if (!rst_n) begin
            sleep_q <= 1'b0;
            wake_armed <= 3'h0;
            wake_vector_o <= 1'b0;
            wake_resume_o <= 1'b0;
        end else begin
            sleep_q <= core_sleep_i;
            if (core_sleep_i & ~sleep_q)
                wake_armed <= ext_en;
            wake_vector_o <= wake & global_irq_enable;
            wake_resume_o <= wake & ~global_irq_enable;
        end
    end

    // ****************************************
    // Return stack and fast shadow store
    // ****************************************
    assign stack_full_o = (stack_ptr == `PTIS_STK_FULL);

    // Pushes beyond the last slot are dropped rather than wrapping over old entries.
    always @(posedge clock_i or negedge rst_n) begin
        if (!rst_n) begin
            stack_ptr <= 5'h00;
            return_pc_o <= {`PTIS_PCW{1'b0}};
            shadow_working_o <= `PTIS_ZERO8;
            shadow_status_o <= `PTIS_ZERO8;
            shadow_bank_o <= 4'h0;
        end else if (core_take_i) begin
            if (!stack_full_o) begin
                stack_ptr <= stack_ptr + 5'h01;
            end
            return_pc_o <= core_pc_i;
            shadow_working_o <= core_working_i;
            shadow_status_o <= core_status_i;
            shadow_bank_o <= core_bank_i;
        end else if (core_return_i && stack_ptr != 5'h00) begin
            stack_ptr <= stack_ptr - 5'h01;
            return_pc_o <= stack_mem[stack_ptr - 5'h01];
        end
    end

    // The array has no reset; entries are only read after being written.
    always @(posedge clock_i) begin
        if (core_take_i && !stack_full_o)
            stack_mem[stack_ptr] <= core_pc_i;
    end

    // ****************************************
    // Event status, mask and interrupt line
    // ****************************************
    wire [`PTIS_NSRC-1:0] ev_set = {wake, port_change, timer_ovf, ext_edge};
    wire [`PTIS_NSRC-1:0] ev_clr = wr_hit(`PTIS_REG_STATUS) ? writedata_i[`PTIS_NSRC-1:0] :
                                   {`PTIS_NSRC{1'b0}};

    // Write one to clear; a new event in the same cycle keeps its bit.
    always @(posedge clock_i or negedge rst_n) begin
        if (!rst_n) begin
            event_status <= {`PTIS_NSRC{1'b0}};
            event_mask <= {`PTIS_NSRC{1'b0}};
        end else begin
            event_status <= ev_set | (event_status & ~ev_clr);
            if (wr_hit(`PTIS_REG_MASK))
                event_mask <= writedata_i[`PTIS_NSRC-1:0];
        end
    end

    assign irq_o = |(event_status & event_mask);

    // ****************************************
    // Avalon-MM slave
    // ****************************************
    // One wait cycle per access keeps read data registered.
    assign waitrequest_o = bus_req & ~ack;

    // Read mux; unmapped indices read as zero and writes to them are dropped.
    reg [31:0] next_readdata;
    always @* begin
        next_readdata = 32'h00000000;
        case (address_i)
            `PTIS_REG_MAIN: next_readdata[7:0] = main_irq_control;
            `PTIS_REG_SECOND: next_readdata[7:0] = second_irq_control;
            `PTIS_REG_THIRD: next_readdata[7:0] = third_irq_control;
            `PTIS_REG_TMODE: next_readdata[1:0] = timer_mode;
            `PTIS_REG_TLOW: next_readdata[7:0] = timer_zero_count_low;
            `PTIS_REG_THIGH: next_readdata[7:0] = timer_zero_count_high;
            `PTIS_REG_STATUS: next_readdata[`PTIS_NSRC-1:0] = event_status;
            `PTIS_REG_MASK: next_readdata[`PTIS_NSRC-1:0] = event_mask;
            default: next_readdata = 32'h00000000;
        endcase
    end

    always @(posedge clock_i or negedge rst_n) begin
        if (!rst_n) begin
            ack <= 1'b0;
            readdata_o <= 32'h00000000;
        end else begin
            ack <= bus_req & ~ack;
            if (read_i & ~ack)
                readdata_o <= next_readdata;
        end
    end
endmodule // ptis_irq_top

// ===== hdl/ptis_pin_events.v
`timescale 1ns/100ps
// Synchronises the seven interrupt pins and turns them into one-cycle events.
module ptis_pin_events (
    input wire clock_i,
    input wire rst_n_i,
    input wire [2:0] ext_pins_i,
    input wire [3:0] port_pins_i,
    input wire [2:0] polarity_i,
    output reg [2:0] ext_edge_o,
    output reg port_change_o
);
    reg [6:0] meta;
    reg [6:0] sync;
    reg [6:0] prev;
    reg [3:0] latched;

    // Two-stage synchroniser; only sync reads the first stage.
    always @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            meta <= 7'h00;
            sync <= 7'h00;
            prev <= 7'h00;
            latched <= 4'h0;
            ext_edge_o <= 3'h0;
            port_change_o <= 1'b0;
        end else begin
            meta <= {port_pins_i, ext_pins_i};
            sync <= meta;
            prev <= sync;
            // Rising edge when polarity is one, falling edge otherwise.
            ext_edge_o <= (polarity_i & sync[2:0] & ~prev[2:0]) |
                          (~polarity_i & ~sync[2:0] & prev[2:0]);
            // The latched copy follows the pins so each change flags once.
            port_change_o <= |(sync[6:3] ^ latched);
            latched <= sync[6:3];
        end
    end
endmodule // ptis_pin_events
